// File: hw/nfc_target_pkg.sv
// Purpose: shared constants and types for the target protocol status block
// Assumes: 32-bit apb, register index times four gives the byte address
// Notes: indices are word indices, not byte addresses
package nfc_target_pkg;
   // register indices
   localparam logic [7:0] IRQ_STATUS_IDX = 8'h0C;
   localparam logic [7:0] LOW_FIELD_IDX = 8'h16;
   localparam logic [7:0] DETECT_LEVEL_IDX = 8'h18;
   localparam logic [7:0] TARGET_PROTOCOL_IDX = 8'h19;
   localparam logic [7:0] ANALOG_TEST_IDX = 8'h1A;
   localparam logic [7:0] FIFO_STATUS_IDX = 8'h1C;

   // reset values
   localparam logic [7:0] TARGET_PROTOCOL_RST = 8'h00;
   localparam logic [7:0] ANALOG_TEST_RST = 8'h00;
   localparam logic [7:0] LEVEL_RST = 8'h00;
   localparam logic [7:0] IRQ_STATUS_RST = 8'h00;

   // interrupt status codes
   localparam logic [7:0] IRQ_FIELD_DETECT = 8'h04;
   localparam logic [7:0] IRQ_SDD_DONE = 8'h08;
   localparam logic [7:0] IRQ_RX_DONE = 8'h40;

   // target protocol fields
   localparam int WAKE_BIT = 7;
   localparam int COLL_BIT = 6;
   localparam int ALT_CODING_BIT = 4;
   localparam int PASSIVE_106_BIT = 3;
   localparam int TYPEB_BIT = 2;
   localparam int RATE_HI_BIT = 1;
   localparam int RATE_LO_BIT = 0;
   localparam logic [7:0] LATCHED_MASK = 8'h1F;

   // bit rate codes
   localparam logic [1:0] RATE_RESERVED = 2'h0;
   localparam logic [1:0] RATE_106 = 2'h1;
   localparam logic [1:0] RATE_212 = 2'h2;
   localparam logic [1:0] RATE_424 = 2'h3;

   // analog test fields
   localparam int KEY_SUBC_IN_BIT = 7;
   localparam int MOD_PIN_SUBCARRIER_OUT_BIT = 6;
   localparam int DIRECT_MOD_BIT = 5;
   localparam int GAIN_TEST_BIT = 0;

   // level register fields
   localparam int LEVEL_LSB = 0;
   localparam int SDD_EN_BIT = 5;

   // descriptor of the first command seen from a reader or initiator
   typedef struct packed {
      logic alt_coding;
      logic sens_or_all_req;
      logic typeb;
      logic [1:0] rate;
   } cmd_info_s;
endpackage

// File: hw/target_protocol_status_status.sv
// Purpose: target protocol status, test routing and event status over apb
// Assumes: all inputs synchronous to pclk; rf level already digitised
// Notes: chip_enable low clears all registers like power-on, except the detect level register
//
// Behaviour
// RL1: field detect in emulation reports status 04
// RL2: auto sdd completion reports status 08
// RL3: received command frame reports status 40
// RL4: type A reads C9, type B C5
// RL5: host reads four rats bytes, answers itself
// RL6: type B reqb shows three fifo bytes
// RL7: reset zero; bits four..zero clear on read
// RL8: bits seven, six live, never latched
// RL9: bit seven: level above wake threshold
// RL10: bit six: level above collision threshold
// RL11: bit four latches alternate coding
// RL12: bit three latches sens or all request
// RL13: bit two latches type B signalling
// RL14: bits one..zero hold first bit rate
// RL15: test seven: keying pin feeds decoder
// RL16: test six: modulation pin outputs subcarrier
// RL17: test five: modulation pin drives tx, reset
// RL18: test zero: gain level on strength bits
// RL19: zero wake field disables wake comparator
// RL20: read clear acts after data returned
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module target_protocol_status_status
   import nfc_target_pkg::*;
#(
   parameter int LEVEL_W = 3,
   parameter int RSSI_W = 3
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic chip_enable,
   input wire logic card_emulation,
   input wire logic field_detect,
   input wire logic sdd_done,
   input wire logic rx_done,
   input wire logic cmd_valid,
   input wire cmd_info_s cmd_info,
   input wire logic [6:0] fifo_count,
   input wire logic fifo_overflow,
   input wire logic [LEVEL_W-1:0] rf_level,
   input wire logic [RSSI_W-1:0] rssi_level,
   input wire logic [RSSI_W-1:0] gain_level,
   output logic [RSSI_W-1:0] rssi_status,
   output logic irq,
   input wire logic coder_keying,
   input wire logic demod_data,
   input wire logic coder_modulation,
   input wire logic rx_subcarrier,
   input wire logic keying_pin_i,
   output logic keying_pin_o,
   output logic keying_pin_oe,
   input wire logic modulation_pin_i,
   output logic modulation_pin_o,
   output logic modulation_pin_oe,
   output logic decoder_in,
   output logic tx_modulation,
   output logic rx_reset
);

   initial
   begin
      if (LEVEL_W < 3 || LEVEL_W > 8)
         $error("LEVEL_W must be 3 to 8");
      if (RSSI_W < 1 || RSSI_W > 8)
         $error("RSSI_W must be 1 to 8");
   end

   logic [4:0] latched_reg;
   logic first_seen_reg;
   logic [7:0] test_reg;
   logic [7:0] low_field_reg;
   logic [7:0] detect_level_reg;
   logic [7:0] irq_status_reg;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pslverr_reg;
   logic hit_next;
   logic wake_flag;
   logic coll_flag;
   logic [7:0] protocol_view;
   logic setup;
   logic access_done;
   logic wr_done;
   logic rd_done;
   logic [7:0] word_idx;
   logic [7:0] acc_idx;
   logic [8:0] dec_idx;

   // word index from a byte address; misaligned addresses never decode
   function automatic logic [8:0] decode_idx(input logic [31:0] addr);
      if (addr[1:0] != 2'h0 || addr[31:10] != 22'h0)
         decode_idx = 9'h100;
      else
         decode_idx = {1'b0, addr[9:2]};
   endfunction

   function automatic logic above(input logic [LEVEL_W-1:0] lvl,
                                  input logic [2:0] thr);
      above = lvl > LEVEL_W'(thr);
   endfunction

   assign setup = psel && !penable;
   assign access_done = psel && penable;
   assign wr_done = access_done && pwrite;
   assign rd_done = access_done && !pwrite;
   assign acc_idx = paddr[9:2];
   assign dec_idx = decode_idx(paddr);
   assign word_idx = dec_idx[7:0];

   // live comparators
   assign wake_flag = (detect_level_reg[LEVEL_LSB +: 3] != 3'h0) && // RL19
                      above(rf_level, detect_level_reg[LEVEL_LSB +: 3]); // RL9
   assign coll_flag = above(rf_level, low_field_reg[LEVEL_LSB +: 3]); // RL10

   // bits seven and six bypass the latches entirely
   assign protocol_view = {wake_flag, coll_flag, 1'b0, latched_reg}; // RL8

   // first command descriptor, held until the host reads it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         latched_reg <= TARGET_PROTOCOL_RST[4:0];
         first_seen_reg <= 1'b0;
      end
      else if (!chip_enable)
      begin
         latched_reg <= TARGET_PROTOCOL_RST[4:0]; // RL7
         first_seen_reg <= 1'b0;
      end
      else if (cmd_valid && !first_seen_reg)
      begin
         // a new first command beats a read clear in the same cycle
         latched_reg[ALT_CODING_BIT] <= cmd_info.alt_coding; // RL11
         latched_reg[PASSIVE_106_BIT] <= cmd_info.sens_or_all_req; // RL12
         latched_reg[TYPEB_BIT] <= cmd_info.typeb; // RL13
         latched_reg[RATE_HI_BIT:RATE_LO_BIT] <= cmd_info.rate; // RL14
         first_seen_reg <= 1'b1; // RL4
      end
      else if (rd_done && acc_idx == TARGET_PROTOCOL_IDX &&
               decode_idx(paddr) != 9'h100)
      begin
         // clear lands on the access edge, data already captured in setup
         latched_reg <= TARGET_PROTOCOL_RST[4:0]; // RL7 RL20
         first_seen_reg <= 1'b0;
      end
   end

   // event status, read to clear, set beats clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_status_reg <= IRQ_STATUS_RST;
      else if (!chip_enable)
         irq_status_reg <= IRQ_STATUS_RST;
      else
      begin
         logic [7:0] keep;
         logic [7:0] set;
         keep = irq_status_reg;
         set = 8'h00;
         if (rd_done && word_idx == IRQ_STATUS_IDX)
            keep = 8'h00;
         if (field_detect && card_emulation)
            set = set | IRQ_FIELD_DETECT; // RL1
         if (sdd_done && detect_level_reg[SDD_EN_BIT])
            set = set | IRQ_SDD_DONE; // RL2
         if (rx_done && card_emulation)
            set = set | IRQ_RX_DONE; // RL3
         irq_status_reg <= keep | set;
      end
   end

   assign irq = irq_status_reg != 8'h00; // RL1 RL2 RL3

   // software written configuration
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         test_reg <= ANALOG_TEST_RST;
         low_field_reg <= LEVEL_RST;
      end
      else if (!chip_enable)
      begin
         test_reg <= ANALOG_TEST_RST;
         low_field_reg <= LEVEL_RST;
      end
      else if (wr_done && word_idx == ANALOG_TEST_IDX)
         test_reg <= pwdata[7:0];
      else if (wr_done && word_idx == LOW_FIELD_IDX)
         low_field_reg <= pwdata[7:0];
   end

   // wake level and sdd enable survive enable low, reset only at power-on
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         detect_level_reg <= LEVEL_RST;
      else if (wr_done && word_idx == DETECT_LEVEL_IDX)
         detect_level_reg <= pwdata[7:0];
   end

   // read mux; data captured in the setup cycle
   always_comb
   begin
      prdata_next = 32'h0000_0000;
      hit_next = 1'b1;
      unique case (decode_idx(paddr))
         {1'b0, IRQ_STATUS_IDX}: prdata_next[7:0] = irq_status_reg;
         {1'b0, LOW_FIELD_IDX}: prdata_next[7:0] = low_field_reg;
         {1'b0, DETECT_LEVEL_IDX}: prdata_next[7:0] = detect_level_reg;
         {1'b0, TARGET_PROTOCOL_IDX}: prdata_next[7:0] = protocol_view; // RL4
         {1'b0, ANALOG_TEST_IDX}: prdata_next[7:0] = test_reg;
         {1'b0, FIFO_STATUS_IDX}:
            prdata_next[7:0] = {fifo_overflow, fifo_count}; // RL6
         default: hit_next = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
      else if (setup)
      begin
         prdata_reg <= pwrite ? 32'h0000_0000 : prdata_next;
         pslverr_reg <= !hit_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = 1'b1;
   assign pslverr = pslverr_reg && access_done;

   // signal strength view
   assign rssi_status = test_reg[GAIN_TEST_BIT] ? gain_level : rssi_level; // RL18

   // keying pin routing
   assign keying_pin_oe = !test_reg[KEY_SUBC_IN_BIT]; // RL15
   assign keying_pin_o = test_reg[KEY_SUBC_IN_BIT] ? 1'b0 : coder_keying;
   assign decoder_in = test_reg[KEY_SUBC_IN_BIT] ? keying_pin_i : // RL15
                       demod_data;

   // modulation pin routing; direct drive wins over subcarrier out
   always_comb
   begin
      modulation_pin_oe = 1'b1;
      modulation_pin_o = coder_modulation;
      tx_modulation = coder_modulation;
      rx_reset = 1'b0;
      if (test_reg[DIRECT_MOD_BIT])
      begin
         modulation_pin_oe = 1'b0; // RL17
         modulation_pin_o = 1'b0;
         tx_modulation = modulation_pin_i; // RL17
         rx_reset = modulation_pin_i;
      end
      else if (test_reg[MOD_PIN_SUBCARRIER_OUT_BIT])
         modulation_pin_o = rx_subcarrier; // RL16
   end

endmodule
`default_nettype wire

// File: testbench/target_status_props.sv
// Purpose: port checks for the target protocol status block
// Assumes: one pclk domain; test register mirrored from apb writes
// Notes: bound to the block at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module target_status_props
   import nfc_target_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic chip_enable,
   input wire logic card_emulation,
   input wire logic rx_done,
   input wire logic irq,
   input wire logic keying_pin_i,
   input wire logic keying_pin_oe,
   input wire logic decoder_in,
   input wire logic modulation_pin_i,
   input wire logic modulation_pin_o,
   input wire logic modulation_pin_oe,
   input wire logic rx_subcarrier,
   input wire logic tx_modulation,
   input wire logic rx_reset
);
   logic [7:0] t_reg;
   logic wr_test;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   assign wr_test = psel && penable && pwrite
      && paddr == {22'h0, ANALOG_TEST_IDX, 2'h0};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn || !chip_enable)
         t_reg <= 8'h00;
      else if (wr_test)
         t_reg <= pwdata[7:0];
   end
   sequence ce_low2;
      !chip_enable ##1 !chip_enable;
   endsequence
   a_key_oe: assert property (t_reg[7] |-> !keying_pin_oe)
      else $error("keying pin driven in input mode");
   a_key_decode: assert property (t_reg[7] |-> decoder_in == keying_pin_i)
      else $error("decoder not fed from keying pin");
   a_mod_sub: assert property (t_reg[6] && !t_reg[5]
      |-> modulation_pin_oe && modulation_pin_o == rx_subcarrier)
      else $error("subcarrier not on modulation pin");
   a_mod_input: assert property (t_reg[5] |-> !modulation_pin_oe)
      else $error("modulation pin driven in input mode");
   a_mod_drive: assert property (t_reg[5] |-> tx_modulation ==
      modulation_pin_i && rx_reset == modulation_pin_i)
      else $error("modulation pin does not steer tx");
   a_rst_idle: assert property (!t_reg[5] |-> !rx_reset)
      else $error("receiver reset outside direct mode");
   a_rx_irq: assert property (chip_enable && card_emulation
      && rx_done |=> irq)
      else $error("no interrupt after frame");
   a_ce_clear: assert property (ce_low2 |-> !irq)
      else $error("interrupt survives disable");
endmodule
bind target_protocol_status_status target_status_props chk (.*);
`default_nettype wire

// File: testbench/rf_reader_model.sv
// Purpose: remote reader or initiator seen through the rf front end
// Assumes: events reach the block as one-cycle pulses on pclk
// Notes: command info is scrambled once its pulse is over
`timescale 1ns/100ps
`default_nettype none
module rf_reader_model
   import nfc_target_pkg::*;
(
   input wire logic pclk,
   output logic field_detect = 1'b0,
   output logic sdd_done = 1'b0,
   output logic rx_done = 1'b0,
   output logic cmd_valid = 1'b0,
   output var cmd_info_s cmd_info = 5'h00,
   output logic [2:0] rf_level = 3'h0
);
   task automatic send(input cmd_info_s info);
      @(posedge pclk);
      cmd_info <= info;
      cmd_valid <= 1'b1;
      @(posedge pclk);
      cmd_info <= ~info;
      cmd_valid <= 1'b0;
   endtask
   // 0 field seen, 1 anticollision done, 2 frame received
   task automatic pulse(input int k);
      @(posedge pclk);
      {rx_done, sdd_done, field_detect} <= 3'(1 << k);
      @(posedge pclk);
      {rx_done, sdd_done, field_detect} <= 3'h0;
   endtask
   task automatic level(input logic [2:0] v);
      @(posedge pclk);
      rf_level <= v;
   endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Purpose: register and routing tests for the target protocol block
// Assumes: apb master below, reader events from rf_reader_model
// Notes: thresholds used are 3 for wake-up and 2 for collision
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import nfc_target_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
   logic pready, pslverr, irq, keying_pin_o, keying_pin_oe;
   logic modulation_pin_o, modulation_pin_oe, decoder_in;
   logic tx_modulation, rx_reset, keying_pin_i, modulation_pin_i;
   logic field_detect, sdd_done, rx_done, cmd_valid;
   cmd_info_s cmd_info;
   logic [2:0] rf_level, rssi_status;
   logic [2:0] rssi_level = 3'h2, gain_level = 3'h5;
   logic chip_enable = 1'b1, card_emulation = 1'b0;
   logic fifo_overflow = 1'b0, coder_keying = 1'b1;
   logic demod_data = 1'b0, coder_modulation = 1'b0;
   logic rx_subcarrier = 1'b1, key_drv = 1'b0, mod_drv = 1'b0;
   logic [6:0] fifo_count = 7'h00;
   logic [4:0] cmds [4] = '{5'h09, 5'h05, 5'h12, 5'h03};
   logic [7:0] cexp [4] = '{8'hC9, 8'hC5, 8'hD2, 8'hC3};
   logic [2:0] lv [3] = '{3'h2, 3'h3, 3'h4};
   logic [7:0] lexp [3] = '{8'h00, 8'h40, 8'hC0};
   logic [7:0] iexp [3] = '{IRQ_FIELD_DETECT, IRQ_SDD_DONE, IRQ_RX_DONE};
   int n_fail = 0, checks_done = 0;
   // pin level resolved from whichever side drives it
   assign keying_pin_i = keying_pin_oe ? keying_pin_o : key_drv;
   assign modulation_pin_i = modulation_pin_oe ? modulation_pin_o : mod_drv;
   target_protocol_status_status dut (.*);
   rf_reader_model rdr (.*);
   always #12.5 pclk = ~pclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // answer is taken at the rising edge where pready is sampled high
   task automatic apb(input logic w, input logic [7:0] idx,
      input logic [7:0] d, output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {22'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, idx, 8'h00, q, e);
      chk(q, {24'h0, exp});
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, idx, d, q, e);
   endtask
   initial
   begin
      logic [31:0] q;
      logic e;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(TARGET_PROTOCOL_IDX, TARGET_PROTOCOL_RST);
      rd(ANALOG_TEST_IDX, ANALOG_TEST_RST);
      $display("test reset done");
      wr(DETECT_LEVEL_IDX, 8'h23);
      wr(LOW_FIELD_IDX, 8'h02);
      rdr.level(3'h5);
      // second command must not overwrite the first
      for (int i = 0; i < 4; i++)
      begin
         rdr.send(cmds[i]);
         rdr.send(5'h1C);
         rd(TARGET_PROTOCOL_IDX, cexp[i]);
         rd(TARGET_PROTOCOL_IDX, 8'hC0);
      end
      $display("test first command done");
      for (int i = 0; i < 3; i++)
      begin
         rdr.level(lv[i]);
         rd(TARGET_PROTOCOL_IDX, lexp[i]);
      end
      wr(DETECT_LEVEL_IDX, 8'h20);
      rdr.level(3'h7);
      rd(TARGET_PROTOCOL_IDX, 8'h40);
      $display("test levels done");
      card_emulation <= 1'b1;
      for (int i = 0; i < 3; i++)
      begin
         rdr.pulse(i);
         rd(IRQ_STATUS_IDX, iexp[i]);
      end
      fifo_count <= 7'h04;
      rd(FIFO_STATUS_IDX, 8'h04);
      card_emulation <= 1'b0;
      rdr.pulse(0);
      rd(IRQ_STATUS_IDX, 8'h00);
      fifo_count <= 7'h03;
      rd(FIFO_STATUS_IDX, 8'h03);
      $display("test events done");
      wr(ANALOG_TEST_IDX, 8'hA1);
      key_drv <= 1'b1;
      mod_drv <= 1'b1;
      rd(ANALOG_TEST_IDX, 8'hA1);
      @(negedge pclk);
      chk(32'(rssi_status), 32'(gain_level));
      chk(32'(decoder_in), 32'h1);
      chk(32'(rx_reset), 32'h1);
      wr(ANALOG_TEST_IDX, 8'h40);
      @(negedge pclk);
      chk(32'(modulation_pin_o), 32'(rx_subcarrier));
      chip_enable <= 1'b0;
      repeat (2) @(posedge pclk);
      chip_enable <= 1'b1;
      rd(ANALOG_TEST_IDX, 8'h00);
      apb(1'b0, 8'hFF, 8'h00, q, e);
      chk(32'(e), 32'h1);
      $display("test routing done");
      print_verdict();
   end
   // about 28 transfers of three cycles; ample margin
   initial
   begin
      #100000;
      n_fail++;
      print_verdict();
   end
endmodule
`default_nettype wire
